/* File: logic/drbc_refresh_ctrl.sv */
/*
 * refresh command decode, bank refresh counter and row refresh counter.
 * assumes cs_i and ca_i are already in the clk_i domain (command bus sampled
 * on the memory clock); the controller keeps all its spacing rules.
 */
`timescale 1ns/100ps
`default_nettype none
`include "drbc_defines.svh"
module drbc_refresh_ctrl (
    input  wire logic                     clk_i,
    input  wire logic                     sys_rst_i,
    input  wire logic                     cs_i,
    input  wire logic [`DRBC_CA_W-1:0]    ca_i,
    input  wire logic                     self_refresh_exit_i,
    output logic [`DRBC_BANK_W-1:0]       bank_count_o,
    output logic [`DRBC_ROW_W-1:0]        row_count_o,
    output logic [7:0]                    bank_busy_o,
    output logic                          all_busy_o,
    output logic                          per_bank_refresh_o,
    output logic                          all_bank_refresh_o,
    output logic [`DRBC_BANK_W-1:0]       refresh_bank_o,
    output logic [`DRBC_ROW_W-1:0]        refresh_row_o
);
    drbc_pkg::drbc_dec_t               st_q, st_d;
    logic [`DRBC_BANK_W-1:0]           bcnt_q, bcnt_d;
    logic [`DRBC_ROW_W-1:0]            row_q, row_d;
    logic                              pb_q, pb_d, ab_q, ab_d;
    logic [`DRBC_BANK_W-1:0]           rbank_q, rbank_d;
    logic [`DRBC_ROW_W-1:0]            rrow_q, rrow_d;
    logic                              is_ref;
    logic [7:0]                        pb_load;
    logic                              ab_load;

    // first-edge decode of a refresh command
    assign is_ref = cs_i && (ca_i[4:0] == `DRBC_CMD_REF);

    always_comb begin
        st_d      = st_q;
        bcnt_d    = bcnt_q;
        row_d     = row_q;
        pb_d      = 1'b0;
        ab_d      = 1'b0;
        rbank_d   = rbank_q;
        rrow_d    = rrow_q;
        case (st_q)
            drbc_pkg::DRBC_IDLE: begin
                if (self_refresh_exit_i) begin
                    bcnt_d = '0;
                end else if (is_ref && ca_i[5]) begin
                    // row used now, next refresh of any type sees row + 1
                    ab_d      = 1'b1;
                    rrow_d    = row_q;
                    bcnt_d    = '0;
                    row_d     = row_q + 16'h0001;
                end else if (is_ref) begin
                    st_d = drbc_pkg::DRBC_PB_BANK;
                end
            end
            drbc_pkg::DRBC_PB_BANK: begin
                st_d      = drbc_pkg::DRBC_IDLE;
                pb_d      = 1'b1;
                rbank_d   = ca_i[2:0];
                rrow_d    = row_q;
                bcnt_d    = bcnt_q + 3'h1;
                // wrap from seven closes the round and moves the row on
                if (bcnt_q == 3'h7) begin
                    row_d = row_q + 16'h0001;
                end
            end
            default: begin
                st_d = drbc_pkg::DRBC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_q      <= drbc_pkg::DRBC_IDLE;
            bcnt_q    <= '0;
            row_q     <= '0;
            pb_q      <= 1'b0;
            ab_q      <= 1'b0;
            rbank_q   <= '0;
            rrow_q    <= '0;
        end else begin
            st_q      <= st_d;
            bcnt_q    <= bcnt_d;
            row_q     <= row_d;
            pb_q      <= pb_d;
            ab_q      <= ab_d;
            rbank_q   <= rbank_d;
            rrow_q    <= rrow_d;
        end
    end

    // one timer per bank so the others stay usable
    assign ab_load = ab_q;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_bank
            assign pb_load[gi] = pb_q && (rbank_q == 3'(gi));
            drbc_bank_timer u_tmr (
                .clk_i     (clk_i),
                .sys_rst_i (sys_rst_i),
                .load_i    (pb_load[gi] | ab_load),
                .count_i   (ab_load ? 8'(`DRBC_RFC_AB_CYC) : 8'(`DRBC_RFC_PB_CYC)),
                .busy_o    (bank_busy_o[gi])
            );
        end
    endgenerate

    drbc_bank_timer u_all (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .load_i    (ab_load),
        .count_i   (8'(`DRBC_RFC_AB_CYC)),
        .busy_o    (all_busy_o)
    );

    assign bank_count_o       = bcnt_q;
    assign row_count_o        = row_q;
    assign per_bank_refresh_o = pb_q;
    assign all_bank_refresh_o = ab_q;
    assign refresh_bank_o     = rbank_q;
    assign refresh_row_o      = rrow_q;

    property p_ab_clears;
        @(posedge clk_i) disable iff (sys_rst_i)
        (st_q == drbc_pkg::DRBC_IDLE && !self_refresh_exit_i && is_ref && ca_i[5])
            |=> (bcnt_q == 3'h0) && ab_q;
    endproperty
    a_ab_clears: assert property (p_ab_clears) else $error("all-bank did not clear");

    property p_pb_bank;
        @(posedge clk_i) disable iff (sys_rst_i)
        (st_q == drbc_pkg::DRBC_PB_BANK) |=> pb_q && (rbank_q == $past(ca_i[2:0]));
    endproperty
    a_pb_bank: assert property (p_pb_bank) else $error("per-bank bank wrong");

    property p_pb_two_edges;
        @(posedge clk_i) disable iff (sys_rst_i)
        (st_q == drbc_pkg::DRBC_IDLE && !self_refresh_exit_i && is_ref && !ca_i[5])
            |=> !pb_q ##1 pb_q;
    endproperty
    a_pb_two_edges: assert property (p_pb_two_edges) else $error("per-bank timing");

    property p_no_ref_nocs;
        @(posedge clk_i) disable iff (sys_rst_i)
        (st_q == drbc_pkg::DRBC_IDLE && !cs_i) |=> !ab_q && st_q == drbc_pkg::DRBC_IDLE;
    endproperty
    a_no_ref_nocs: assert property (p_no_ref_nocs) else $error("spurious refresh");

    property p_srx_zero;
        @(posedge clk_i) disable iff (sys_rst_i)
        (st_q == drbc_pkg::DRBC_IDLE && self_refresh_exit_i) |=> bcnt_q == 3'h0;
    endproperty
    a_srx_zero: assert property (p_srx_zero) else $error("exit did not zero");

    property p_wrap_row;
        @(posedge clk_i) disable iff (sys_rst_i)
        (st_q == drbc_pkg::DRBC_PB_BANK && bcnt_q == 3'h7)
            |=> bcnt_q == 3'h0 && row_q == $past(row_q) + 16'h0001;
    endproperty
    a_wrap_row: assert property (p_wrap_row) else $error("wrap missed row");

    property p_ab_row_inc;
        @(posedge clk_i) disable iff (sys_rst_i)
        ab_q |-> row_q == refresh_row_o + 16'h0001;
    endproperty
    a_ab_row_inc: assert property (p_ab_row_inc) else $error("row not advanced");

    property p_pb_busy;
        @(posedge clk_i) disable iff (sys_rst_i)
        (pb_q && !ab_q && rbank_q == 3'h0 && !bank_busy_o[0])
            |=> bank_busy_o[0] [*3] ##1 !bank_busy_o[0] || pb_q || ab_q;
    endproperty
    a_pb_busy: assert property (p_pb_busy) else $error("bank busy span wrong");

    property p_ab_busy;
        @(posedge clk_i) disable iff (sys_rst_i)
        ab_q |=> all_busy_o && (&bank_busy_o);
    endproperty
    a_ab_busy: assert property (p_ab_busy) else $error("all-bank busy missing");
endmodule
`default_nettype wire

/* File: inc/drbc_defines.svh */
/*
 * constants for the refresh bank counter: command encodings, widths, cycle times.
 * assumes inclusion by bare name from the design files.
 */
`ifndef DRBC_DEFINES_SVH
`define DRBC_DEFINES_SVH

`define DRBC_CA_W            6
`define DRBC_BANK_W          3
`define DRBC_ROW_W           16
`define DRBC_CMD_REF         5'h08
`define DRBC_CLK_NS          50
`define DRBC_RFC_PB_NS       140
`define DRBC_RFC_AB_NS       280
`define DRBC_RFC_PB_CYC      ((`DRBC_RFC_PB_NS + `DRBC_CLK_NS - 1) / `DRBC_CLK_NS)
`define DRBC_RFC_AB_CYC      ((`DRBC_RFC_AB_NS + `DRBC_CLK_NS - 1) / `DRBC_CLK_NS)
`define DRBC_TMR_W           8

`endif

/* File: inc/drbc_pkg.sv */
/*
 * types for the refresh bank counter.
 * assumes drbc_defines.svh is compiled alongside.
 */
`include "drbc_defines.svh"
package drbc_pkg;
    typedef enum logic [1:0] {
        DRBC_IDLE,
        DRBC_PB_BANK
    } drbc_dec_t;
endpackage

/* File: logic/drbc_bank_timer.sv */
/*
 * refresh busy timer, per bank and all-bank: loads a cycle count, reports busy until zero.
 * assumes the load is a one-cycle pulse on clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
`include "drbc_defines.svh"
module drbc_bank_timer (
    input  wire logic                    clk_i,
    input  wire logic                    sys_rst_i,
    input  wire logic                    load_i,
    input  wire logic [`DRBC_TMR_W-1:0]  count_i,
    output logic                         busy_o
);
    logic [`DRBC_TMR_W-1:0] cnt_q;
    logic [`DRBC_TMR_W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (load_i) begin
            cnt_d = count_i;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign busy_o = (cnt_q != '0);
endmodule
`default_nettype wire

/* File: dv/drbc_ctl_model.sv */
/*
 * memory-controller model: issues refresh commands on cs/ca.
 * assumes its tasks are called away from the rising clock edge.
 */
`timescale 1ns/100ps
`default_nettype none
module drbc_ctl_model (
    input  wire logic       clk_i,
    output logic            cs_o = 1'b0,
    output logic [5:0]      ca_o = 6'h00,
    output logic            sr_exit_o = 1'b0
);
    task automatic cmd(input logic cs, input logic [5:0] ca);
        @(posedge clk_i);
        cs_o <= cs;
        ca_o <= ca;
    endtask
    // released bus shows the inverse so a stale code never looks valid
    task automatic release_bus();
        @(posedge clk_i);
        cs_o <= 1'b0;
        ca_o <= ~ca_o;
    endtask
    // only refreshes, never activates, and none postponed or bunched
    task automatic per_bank(input logic [2:0] bank);
        cmd(1'b1, 6'h08);
        cmd(1'b0, {3'h0, bank});
        release_bus();
    endtask
    task automatic all_bank();
        cmd(1'b1, 6'h28);
        release_bus();
    endtask
    task automatic sr_exit();
        @(posedge clk_i);
        sr_exit_o <= 1'b1;
        @(posedge clk_i);
        sr_exit_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: dv/tb_drbc_refresh_ctrl.sv */
/*
 * testbench for the refresh bank counter, with a controller model.
 * assumes busy clears after the cycle counts in the defines.
 */
`timescale 1ns/100ps
`default_nettype none
`include "drbc_defines.svh"
module tb_drbc_refresh_ctrl;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        cs_i;
    logic [5:0]  ca_i;
    logic        sr_exit;
    logic [2:0]  bank_cnt;
    logic [15:0] row_cnt;
    logic [7:0]  bank_busy;
    logic        all_busy;
    logic        pb_pls;
    logic        ab_pls;
    logic [2:0]  ref_bank;
    logic [15:0] ref_row;
    int          fail_count = 0;
    int          n_tests = 0;
    logic [15:0] exp_row = 16'h0000;
    logic [2:0]  exp_cnt = 3'h0;
    always #25 clk_i = ~clk_i;
    drbc_ctl_model u_ctl (.clk_i(clk_i), .cs_o(cs_i), .ca_o(ca_i), .sr_exit_o(sr_exit));
    drbc_refresh_ctrl uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_i(cs_i), .ca_i(ca_i),
        .self_refresh_exit_i(sr_exit), .bank_count_o(bank_cnt), .row_count_o(row_cnt),
        .bank_busy_o(bank_busy), .all_busy_o(all_busy), .per_bank_refresh_o(pb_pls),
        .all_bank_refresh_o(ab_pls), .refresh_bank_o(ref_bank), .refresh_row_o(ref_row));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wait_pulse(input bit ab);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 4 && !seen; i++) begin
            @(negedge clk_i);
            seen = ab ? (ab_pls === 1'b1) : (pb_pls === 1'b1);
        end
        check(seen, 1'b1);
    endtask
    // each waits out its busy span, so spacing stays legal
    task automatic do_pb(input logic [2:0] b);
        u_ctl.per_bank(b);
        wait_pulse(1'b0);
        check(ref_bank, b);
        check(ref_row, exp_row);
        exp_cnt = exp_cnt + 3'h1;
        if (exp_cnt == 3'h0) begin
            exp_row = exp_row + 16'h0001;
        end
        check(bank_cnt, exp_cnt);
        check(row_cnt, exp_row);
        @(negedge clk_i);
        check(pb_pls, 1'b0);
        check(bank_busy, 8'h01 << b);
        repeat (`DRBC_RFC_PB_CYC) @(negedge clk_i);
        check(bank_busy, 8'h00);
    endtask
    task automatic do_ab();
        u_ctl.all_bank();
        wait_pulse(1'b1);
        check(ref_row, exp_row);
        exp_row = exp_row + 16'h0001;
        exp_cnt = 3'h0;
        check(bank_cnt, 3'h0);
        check(row_cnt, exp_row);
        @(negedge clk_i);
        check(ab_pls, 1'b0);
        check(all_busy, 1'b1);
        check(bank_busy, 8'hff);
        repeat (`DRBC_RFC_AB_CYC) @(negedge clk_i);
        check(all_busy, 1'b0);
        check(bank_busy, 8'h00);
    endtask
    task automatic t_reset();
        check(bank_cnt, 3'h0);
        check(row_cnt, 16'h0000);
        check({bank_busy, all_busy, pb_pls, ab_pls}, 11'h000);
    endtask
    task automatic t_decode();
        for (int k = 0; k < 6; k++) begin
            u_ctl.cmd(k != 5, k == 5 ? 6'h08 : 6'h08 ^ (6'h01 << k));
            u_ctl.release_bus();
            repeat (4) begin
                @(negedge clk_i);
                check({pb_pls, ab_pls}, 2'b00);
            end
            check(bank_cnt, exp_cnt);
        end
    endtask
    task automatic t_rounds();
        logic [2:0] ord [16] = '{1, 3, 0, 2, 4, 7, 5, 6, 7, 1, 3, 5, 0, 4, 2, 6};
        foreach (ord[i]) begin
            do_pb(ord[i]);
        end
    endtask
    task automatic t_ab_mid();
        do_pb(3'h0);
        do_pb(3'h1);
        do_pb(3'h2);
        do_ab();
        do_ab();
        do_pb(3'h6);
    endtask
    task automatic t_sr_exit();
        do_pb(3'h3);
        u_ctl.sr_exit();
        @(negedge clk_i);
        exp_cnt = 3'h0;
        check(bank_cnt, 3'h0);
        check(row_cnt, exp_row);
        do_pb(3'h5);
    endtask
    // reset in mid-round must drop both counters
    task automatic t_mid_reset();
        do_pb(3'h4);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(negedge clk_i);
        exp_cnt = 3'h0;
        exp_row = 16'h0000;
        check(bank_cnt, 3'h0);
        check(row_cnt, 16'h0000);
        do_pb(3'h4);
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(negedge clk_i);
        t_reset();
        t_decode();
        t_rounds();
        t_ab_mid();
        t_sr_exit();
        t_mid_reset();
        print_verdict();
    end
    initial begin
        repeat (4000) @(posedge clk_i);
        fail_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
